//--- verilog/bcd_real_muldiv_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "muldiv_defs.vh"
module bcd_real_muldiv_unit (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [7:0] status_q
);
  // ****************************************
  // helpers
  // ****************************************
  function bcd_ok;
    input [31:0] v;
    integer i;
    begin
      bcd_ok = 1'b1;
      for (i = 0; i < 8; i = i + 1)
        if (v[i*4+:4] > 4'h9)
          bcd_ok = 1'b0;
    end
  endfunction

  function [26:0] bcd2bin;
    input [31:0] v;
    integer i;
    begin
      bcd2bin = 27'h0;
      for (i = 7; i >= 0; i = i - 1)
        bcd2bin = bcd2bin * 27'h00000a + {23'h0, v[i*4+:4]};
    end
  endfunction

  // shift-add-3 conversion; 54 bits cover the widest product
  function [63:0] bin2bcd;
    input [53:0] v;
    integer i;
    integer j;
    reg [63:0] b;
    begin
      b = 64'h0;
      for (i = 53; i >= 0; i = i - 1) begin
        for (j = 0; j < 16; j = j + 1)
          if (b[j*4+:4] > 4'h4)
            b[j*4+:4] = b[j*4+:4] + 4'h3;
        b = {b[62:0], v[i]};
      end
      bin2bcd = b;
    end
  endfunction

  // ieee single multiply or divide, truncating; denormals read as zero
  // returns {sign error, underflow, bad operand, result}
  function [34:0] fcore;
    input [31:0] a;
    input [31:0] b;
    input dv;
    reg [47:0] p;
    reg [23:0] ma;
    reg [23:0] mb;
    reg [22:0] m;
    reg [9:0] e;
    reg s;
    reg bad;
    reg uf;
    reg [31:0] r;
    begin
      s = a[31] ^ b[31];
      ma = {1'b1, a[22:0]};
      mb = {1'b1, b[22:0]};
      bad = (a[30:23] == 8'hff) | (b[30:23] == 8'hff);
      uf = 1'b0;
      r = {s, 31'h0};
      p = 48'h0;
      m = 23'h0;
      e = 10'h0;
      if (bad)
        r = `QNAN;
      else if (dv && b[30:23] == 8'h00)
        r = (a[30:23] == 8'h00) ? `QNAN : {s, 8'hff, 23'h0};
      else if (a[30:23] != 8'h00 && b[30:23] != 8'h00) begin
        if (dv) begin
          p = {ma, 24'h0} / {24'h0, mb};
          e = {2'b0, a[30:23]} - {2'b0, b[30:23]} + 10'h07f;
          if (p[24])
            m = p[23:1];
          else begin
            m = p[22:0];
            e = e - 10'h001;
          end
        end else begin
          p = ma * mb;
          e = {2'b0, a[30:23]} + {2'b0, b[30:23]} - 10'h07f;
          if (p[47]) begin
            m = p[46:24];
            e = e + 10'h001;
          end else
            m = p[45:23];
        end
        if (e[9] || e == 10'h000)
          uf = 1'b1;
        else if (e >= 10'h0ff)
          r = {s, 8'hff, 23'h0};
        else
          r = {s, e[7:0], m};
      end
      fcore = {(r[30:23] != 8'hff) & (r[31] != s), uf, bad, r};
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [31:0] acc_q;
  reg [31:0] stk_q;
  reg [31:0] opnd_q;
  reg [15:0] word_q;
  reg [3:0] op_q;
  reg cnst_q;
  reg ptrbad_q;
  reg go_q;

  reg [31:0] acc_d;
  reg [31:0] stk_d;
  reg [15:0] word_d;
  reg [7:0] nf;
  reg [7:0] msk;
  reg [26:0] ua;
  reg [26:0] ub;
  reg [53:0] pb;
  reg [63:0] pd;
  reg [34:0] fr;
  reg ok;
  reg [16:0] sum;

  // ****************************************
  // execution
  // ****************************************
  always @* begin
    acc_d = acc_q;
    stk_d = stk_q;
    word_d = word_q;
    nf = 8'h00;
    msk = 8'h00;
    ua = 27'h0;
    ub = 27'h0;
    pb = 54'h0;
    pd = 64'h0;
    fr = 35'h0;
    ok = 1'b1;
    sum = 17'h0;
    case (op_q)
      `OP_BCD_MUL, `OP_BCD_DIV: begin
        // a constant wider than four digits is not a legal operand
        ok = bcd_ok({16'h0, acc_q[15:0]}) &
             bcd_ok({16'h0, opnd_q[15:0]}) &
             ~(cnst_q & (opnd_q[31:16] != 16'h0));
        ua = bcd2bin({16'h0, acc_q[15:0]});
        ub = bcd2bin({16'h0, opnd_q[15:0]});
        if (op_q == `OP_BCD_MUL) begin
          msk = 8'h43;
          if (ok) begin
            pb = {27'h0, ua} * {27'h0, ub};
            pd = bin2bcd(pb);
            acc_d = pd[31:0];
          end
        end else begin
          msk = 8'hc3;
          if (ok && ub == 27'h0)
            nf[`F_RANGE] = 1'b1;
          else if (ok) begin
            pd = bin2bcd({27'h0, ua / ub});
            acc_d = pd[31:0];
            pd = bin2bcd({27'h0, ua % ub});
            stk_d = pd[31:0];
          end
        end
      end
      `OP_BCD_BCD_MULTIPLY_DOUBLE, `OP_BCD_BCD_DIVIDE_DOUBLE: begin
        // double forms only take a memory word operand, never a constant
        ok = bcd_ok(acc_q) & bcd_ok(opnd_q) & ~cnst_q;
        ua = bcd2bin(acc_q);
        ub = bcd2bin(opnd_q);
        if (op_q == `OP_BCD_BCD_MULTIPLY_DOUBLE) begin
          msk = 8'h43;
          if (ok) begin
            pd = bin2bcd({27'h0, ua} * {27'h0, ub});
            acc_d = pd[31:0];
            stk_d = pd[63:32];
          end
        end else begin
          msk = 8'hc3;
          if (ok && ub == 27'h0)
            nf[`F_RANGE] = 1'b1;
          else if (ok) begin
            pd = bin2bcd({27'h0, ua / ub});
            acc_d = pd[31:0];
            pd = bin2bcd({27'h0, ua % ub});
            stk_d = pd[31:0];
          end
        end
      end
      `OP_REAL_MUL, `OP_REAL_DIV: begin
        msk = 8'h7f;
        fr = fcore(acc_q, opnd_q, op_q == `OP_REAL_DIV);
        if (ptrbad_q)
          nf[`F_PTR] = 1'b1;
        else begin
          acc_d = fr[31:0];
          nf[`F_DATA] = fr[32];
          nf[`F_UNDER] = fr[33];
          nf[`F_SIGN] = fr[34];
        end
      end
      `OP_BCD_INC, `OP_BCD_DEC: begin
        msk = 8'h41;
        ok = bcd_ok({16'h0, opnd_q[15:0]});
        ua = bcd2bin({16'h0, opnd_q[15:0]});
        if (op_q == `OP_BCD_INC)
          ub = (ua == 27'h00270f) ? 27'h0 : ua + 27'h1;
        else
          ub = (ua == 27'h0) ? 27'h00270f : ua - 27'h1;
        pd = bin2bcd({27'h0, ub});
        if (ok)
          word_d = pd[15:0];
        nf[`F_ZERO] = ok & (pd[15:0] == 16'h0);
      end
      `OP_BIN_ADD: begin
        msk = 8'h13;
        sum = {1'b0, acc_q[15:0]} + {1'b0, opnd_q[15:0]};
        acc_d = {15'h0, sum};
        nf[`F_SIGN] = (acc_q[15] == opnd_q[15]) &
                      (sum[15] != acc_q[15]);
      end
      default: msk = 8'h00;
    endcase
    nf[`F_DATA] = nf[`F_DATA] | ~ok;
    if (op_q == `OP_REAL_MUL || op_q == `OP_REAL_DIV) begin
      nf[`F_ZERO] = ~ptrbad_q & (acc_d[30:0] == 31'h0);
      nf[`F_FLOAT] = ~ptrbad_q & (acc_d[30:23] == 8'hff);
    end else if (op_q != `OP_BCD_INC && op_q != `OP_BCD_DEC)
      nf[`F_ZERO] = (acc_d == 32'h0);
    nf[`F_NEG] = acc_d[31];
  end

  // ****************************************
  // apb slave and registers
  // ****************************************
  wire acc_wr;
  wire setup;
  reg [31:0] rd_mux;
  reg hit;

  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pready & pwrite;

  always @* begin
    hit = 1'b1;
    case (paddr)
      `A_CTRL: rd_mux = {22'h0, go_q, 3'h0, ptrbad_q, cnst_q, op_q};
      `A_OPND: rd_mux = opnd_q;
      `A_ACC: rd_mux = acc_q;
      `A_STACK: rd_mux = stk_q;
      `A_STATUS: rd_mux = {24'h0, status_q};
      `A_WORD: rd_mux = {16'h0, word_q};
      default: begin
        rd_mux = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      acc_q <= 32'h0;
      stk_q <= 32'h0;
      opnd_q <= 32'h0;
      word_q <= 16'h0;
      op_q <= 4'h0;
      cnst_q <= 1'b0;
      ptrbad_q <= 1'b0;
      go_q <= 1'b0;
      status_q <= `FLAGS_RST;
    end else begin
      // one wait-free access cycle after every setup cycle
      pready <= setup & ~pready;
      pslverr <= setup & ~hit;
      prdata <= setup ? rd_mux : 32'h0;
      go_q <= 1'b0;
      if (go_q) begin
        acc_q <= acc_d;
        stk_q <= stk_d;
        word_q <= word_d;
        status_q <= (status_q & ~msk) | (nf & msk);
      end
      // an execution in flight wins over a bus write in the same cycle; the write is dropped whatever its offset
      if (acc_wr && !go_q) begin
        case (paddr)
          `A_CTRL: begin
            op_q <= pwdata[3:0];
            cnst_q <= pwdata[`C_CONST];
            ptrbad_q <= pwdata[`C_PTRBAD];
            go_q <= pwdata[`C_START];
          end
          `A_OPND: opnd_q <= pwdata;
          `A_ACC: acc_q <= pwdata;
          `A_STACK: stk_q <= pwdata;
          default: go_q <= 1'b0;
        endcase
      end
    end
  end
endmodule // bcd_real_muldiv_unit
`default_nettype wire

//--- verilog/muldiv_defs.vh
// Contract
// - bcd multiply: operand times accumulator low 16 bits
// - bcd multiply product, eight digits, into accumulator
// - constant operand limited to 0 through 9999
// - double multiply: 8-digit accumulator times 8-digit word
// - double multiply: low digits kept, upper pushed
// - zero flag when accumulator ends zero; increment and decrement set it from the word instead
// - negative flag when accumulator ends negative
// - invalid data flag on non-bcd nibble
// - real multiply of ieee single values
// - pointer fault flag on bad pointer address
// - invalid float flag on bad float result
// - sign error flag on wrong result sign
// - underflow flag on floating point underflow
// - invalid data flag on non-real operand
// - bcd divide: quotient accumulator, remainder stack
// - operand range flag on unusable divisor
// - double divide: memory divisor only, no constant
// - real divide leaves ieee quotient in accumulator
// - bcd increment adds one to word
// - bcd decrement subtracts one from word
// - binary add low 16 bits, 32-bit result
// - flag holds until next writer overwrites it
`ifndef MULDIV_DEFS_VH
`define MULDIV_DEFS_VH
// ****************************************
// register byte offsets
// ****************************************
`define A_CTRL 8'h00
`define A_OPND 8'h04
`define A_ACC 8'h08
`define A_STACK 8'h0c
`define A_STATUS 8'h10
`define A_WORD 8'h14
// ****************************************
// control fields
// ****************************************
`define C_CONST 4
`define C_PTRBAD 5
`define C_START 8
`define C_BUSY 9
// ****************************************
// instruction codes
// ****************************************
`define OP_BCD_MUL 4'h0
`define OP_BCD_BCD_MULTIPLY_DOUBLE 4'h1
`define OP_REAL_MUL 4'h2
`define OP_BCD_DIV 4'h3
`define OP_BCD_BCD_DIVIDE_DOUBLE 4'h4
`define OP_REAL_DIV 4'h5
`define OP_BCD_INC 4'h6
`define OP_BCD_DEC 4'h7
`define OP_BIN_ADD 4'h8
// ****************************************
// status flag positions
// ****************************************
`define F_ZERO 0
`define F_NEG 1
`define F_PTR 2
`define F_FLOAT 3
`define F_SIGN 4
`define F_UNDER 5
`define F_DATA 6
`define F_RANGE 7
`define FLAGS_RST 8'h00
`define QNAN 32'h7fc00000
`endif

//--- tb/bcd_real_muldiv_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "muldiv_defs.vh"
module muldiv_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] status_q
);
  // ********
  // execution tracking
  // ********
  wire go_w;
  logic g1_q;
  logic g2_q;
  logic ptr_q;
  logic [3:0] op_q;
  assign go_w = psel && penable && pready && pwrite &&
    paddr == `A_CTRL && pwdata[`C_START];
  // op is latched at the start write so later bus traffic cannot blur it
  always @(posedge clk) begin
    g1_q <= go_w && !rst;
    g2_q <= g1_q && !rst;
    if (go_w) begin
      op_q <= pwdata[3:0];
      ptr_q <= pwdata[`C_PTRBAD];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside access");
  a_flags_hold: assert property (
    $changed(status_q) && !$past(rst) |-> g2_q)
    else $error("flags moved without an instruction");
  a_mul_scope: assert property (
    g2_q && op_q inside {`OP_BCD_MUL, `OP_BCD_BCD_MULTIPLY_DOUBLE} |->
    (status_q & 8'hbc) == ($past(status_q) & 8'hbc))
    else $error("multiply touched foreign flags");
  a_div_scope: assert property (
    g2_q && op_q inside {`OP_BCD_DIV, `OP_BCD_BCD_DIVIDE_DOUBLE} |->
    (status_q & 8'h3c) == ($past(status_q) & 8'h3c))
    else $error("divide touched foreign flags");
  a_real_scope: assert property (
    g2_q && op_q inside {`OP_REAL_MUL, `OP_REAL_DIV} |->
    status_q[`F_RANGE] == $past(status_q[`F_RANGE]))
    else $error("real op touched range flag");
  a_step_scope: assert property (
    g2_q && op_q inside {`OP_BCD_INC, `OP_BCD_DEC} |->
    (status_q & 8'hbe) == ($past(status_q) & 8'hbe))
    else $error("step touched foreign flags");
  a_add_scope: assert property (
    g2_q && op_q == `OP_BIN_ADD |->
    (status_q & 8'hec) == ($past(status_q) & 8'hec))
    else $error("binary add touched foreign flags");
  a_ptr_cause: assert property (
    $rose(status_q[`F_PTR]) |-> g2_q && ptr_q &&
    op_q inside {`OP_REAL_MUL, `OP_REAL_DIV})
    else $error("pointer fault without bad real pointer");
  a_range_cause: assert property (
    $rose(status_q[`F_RANGE]) |-> g2_q &&
    op_q inside {`OP_BCD_DIV, `OP_BCD_BCD_DIVIDE_DOUBLE})
    else $error("range flag raised outside a divide");
endmodule // muldiv_checker
bind bcd_real_muldiv_unit muldiv_checker i_chk (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .status_q(status_q));
`default_nettype wire

//--- tb/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // ********
  // sequencer side of the bus
  // ********
  initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
  // an idle edge after release keeps back-to-back calls from racing
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule // apb_host_model
`default_nettype wire

//--- tb/tb_bcd_real_muldiv_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "muldiv_defs.vh"
module tb_bcd_real_muldiv_unit;
  logic clk;
  logic rst;
  wire psel, penable, pwrite, pready, pslverr;
  wire [7:0] paddr, status_q;
  wire [31:0] pwdata, prdata;
  int mismatches;
  int samples_checked;
  bcd_real_muldiv_unit i_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_q(status_q));
  apb_host_model i_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********
  // helpers
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    i_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    i_host.xfer(1'b0, a, 32'h0, q, e);
    check(q, exp);
    // offsets that match no register answer with an error; the check expects it only above the last register
    check({31'h0, e}, {31'h0, a > `A_WORD});
  endtask
  task automatic flg(input int b, input logic v);
    check({31'h0, status_q[b]}, {31'h0, v});
  endtask
  // the extra edge lets the flag update land before status_q is sampled
  task automatic ex(input logic [31:0] acc, input logic [31:0] opnd,
                    input logic [7:0] ctl);
    wr(`A_ACC, acc);
    wr(`A_OPND, opnd);
    wr(`A_CTRL, {23'h0, 1'b1, ctl});
    @(posedge clk);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_mul();
    ex(32'h00009999, 32'h00009999, 8'h10);
    chk_reg(`A_ACC, 32'h99980001);
    flg(`F_NEG, 1'b1);
    ex(32'h00000012, 32'h00010000, 8'h10);
    flg(`F_DATA, 1'b1);
    ex(32'h00000012, 32'h0000000a, 8'h00);
    flg(`F_DATA, 1'b1);
    ex(32'h99999999, 32'h99999999, 8'h01);
    flg(`F_NEG, 1'b0);
    chk_reg(`A_ACC, 32'h00000001);
    chk_reg(`A_STACK, 32'h99999998);
  endtask
  task automatic t_div();
    ex(32'h00000100, 32'h00000007, 8'h03);
    chk_reg(`A_ACC, 32'h00000014);
    chk_reg(`A_STACK, 32'h00000002);
    ex(32'h00000100, 32'h00000000, 8'h03);
    flg(`F_RANGE, 1'b1);
    ex(32'h12345678, 32'h00001000, 8'h04);
    chk_reg(`A_ACC, 32'h00012345);
    chk_reg(`A_STACK, 32'h00000678);
    ex(32'h12345678, 32'h00001000, 8'h14);
    flg(`F_DATA, 1'b1);
  endtask
  task automatic t_real();
    ex(32'h40000000, 32'h40400000, 8'h02);
    chk_reg(`A_ACC, 32'h40c00000);
    ex(32'h40c00000, 32'hc0000000, 8'h05);
    flg(`F_NEG, 1'b1);
    chk_reg(`A_ACC, 32'hc0400000);
    ex(32'h40c00000, 32'h40000000, 8'h25);
    flg(`F_PTR, 1'b1);
    chk_reg(`A_ACC, 32'h40c00000);
    chk_reg(`A_CTRL, 32'h00000025);
    ex(32'h7f800000, 32'h40000000, 8'h02);
    flg(`F_FLOAT, 1'b1);
    flg(`F_DATA, 1'b1);
    ex(32'h00800000, 32'h3f000000, 8'h02);
    flg(`F_UNDER, 1'b1);
  endtask
  task automatic t_step_add();
    ex(32'h0, 32'h00009999, 8'h06);
    flg(`F_ZERO, 1'b1);
    chk_reg(`A_WORD, 32'h00000000);
    ex(32'h0, 32'h00001000, 8'h07);
    chk_reg(`A_WORD, 32'h00000999);
    ex(32'h0000ffff, 32'h00000001, 8'h08);
    chk_reg(`A_ACC, 32'h00010000);
    ex(32'h00007fff, 32'h00000001, 8'h08);
    flg(`F_SIGN, 1'b1);
    chk_reg(8'h18, 32'h0);
  endtask
  // a reset in mid-run must clear registers and flags left by earlier ops
  task automatic t_reset();
    wr(`A_STACK, 32'h5a5a5a5a);
    chk_reg(`A_STACK, 32'h5a5a5a5a);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({24'h0, status_q}, 32'h0);
    chk_reg(`A_STACK, 32'h0);
    chk_reg(`A_ACC, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_mul();
    t_div();
    t_real();
    t_step_add();
    t_reset();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_bcd_real_muldiv_unit
`default_nettype wire
